// *** include/scc_pkg.sv ***
package scc_pkg;
	// Coprocessor register numbers
	localparam logic [3:0] REG_IDENT = 4'h0;
	localparam logic [3:0] REG_CONTROL = 4'h1;
	localparam logic [3:0] REG_TABLE_BASE = 4'h2;
	localparam logic [3:0] REG_DOMAIN = 4'h3;
	localparam logic [3:0] REG_FAULT_STATUS = 4'h5;
	localparam logic [3:0] REG_FAULT_ADDRESS = 4'h6;
	localparam logic [3:0] REG_CACHE_OPS = 4'h7;
	localparam logic [3:0] REG_XLAT_OPS = 4'h8;
	localparam logic [3:0] REG_PROCESS_ID = 4'hD;
	// Secondary selectors
	localparam logic [2:0] OP2_ZERO = 3'h0;
	localparam logic [2:0] OP2_ONE = 3'h1;
	localparam logic [3:0] SEC_FIELD_SEVEN = 4'h7;
	// Identification value; arbitrary, low nibble is the revision
	localparam logic [31:0] IDENT_VALUE = 32'h5A5C0011;
	// Control register field positions
	localparam int CTL_XLAT = 0;
	localparam int CTL_ALIGN = 1;
	localparam int CTL_CACHE = 2;
	localparam int CTL_WBUF = 3;
	localparam int CTL_BIGEND = 7;
	localparam int CTL_SYSPROT = 8;
	localparam int CTL_ROMPROT = 9;
	localparam int CTL_HIVEC = 13;
	localparam logic [31:0] CTL_WRITABLE_MASK = 32'h0000238F;
	localparam logic [31:0] CTL_ONES = 32'h00000070;
	localparam logic [31:0] CTL_RESET = 32'h00000000;
	// Field positions and resets
	localparam int TBASE_LSB = 14;
	localparam int CSID_LSB = 25;
	localparam logic [6:0] CSID_RESET = 7'h00;
	localparam logic [8:0] FSTAT_MASK = 9'h0FF;
	localparam logic [31:0] WORD_RESET = 32'h00000000;
	// Coprocessor transfer request
	typedef struct packed {
		logic valid;
		logic write;
		logic privileged;
		logic [3:0] regNum;
		logic [3:0] secField;
		logic [2:0] op2;
		logic [31:0] data;
	} scc_xfer_s;
	// Data fault report from the translation unit
	typedef struct packed {
		logic valid;
		logic prefetch;
		logic [3:0] domain;
		logic [3:0] status;
		logic [31:0] address;
	} scc_fault_s;
endpackage

// *** src/sys_control_coproc_regs.sv ***
// Function
// - Identification read returns fixed value, revision in low nibble; writes ignored.
// - Reset clears every writable control bit.
// - Control bits 0-3 enable translation, alignment, cache, write buffer.
// - Control bits 4-6 read one; writes discarded.
// - Control bit 7 selects big-endian when set.
// - Bits 8 and 9 stored and presented to translation unit.
// - Bit 13 selects high exception vectors.
// - Control bits 12:10, 31:14 read any value; software writes zero.
// - Translation enable takes effect after pipeline fetches, like delayed branch.
// - Table base stores bits 31:14; low bits unpredictable on read.
// - Domain access register fully read/write, sixteen 2-bit fields.
// - Fault status returns low nine bits, bit 8 reads zero.
// - Fault status holds domain in 7:4, fault status code in 3:0.
// - Fault registers update on data faults only, never prefetch faults.
// - Software writes load fault status and address directly.
// - Fault address captures relocated virtual address.
// - Register 7 op2 0 field 7 write invalidates whole cache.
// - Register 8 op2 0 field 7 write invalidates unlocked buffer entries.
// - Register 8 op2 1 field 7 write invalidates entry at given address.
// - Register 13 op2 0 holds context identifier bits 31:25, reset zero.
// - Register 13 op2 1 holds trace identifier; writes notify trace unit.
// - Addresses with top seven bits zero get the context identifier substituted.
// - Only privileged transfers are honoured; others raise undefined trap.
module sys_control_coproc_regs (
	input wire logic core_clk, // Processor clock
	input wire logic rst_b, // Synchronous reset, active low
	input scc_pkg::scc_xfer_s xfer, // Coprocessor transfer request
	input scc_pkg::scc_fault_s fault, // Fault report
	input wire logic [31:0] coreAddr, // Unrelocated core virtual address
	input wire logic fetchBoundary, // Pipeline drained, new control may apply
	output logic [31:0] readData, // Read result
	output logic readValid, // Read result valid
	output logic undefTrap, // Undefined-instruction trap request
	output logic [31:0] relocAddr, // Relocated address to cache and translation
	output logic xlatEnable, // Effective translation enable
	output logic alignCheck, // Alignment checking enable
	output logic cacheEnable, // Cache enable
	output logic wbufEnable, // Write buffer enable
	output logic bigEndian, // Byte order select
	output logic sysProtect, // System protection
	output logic romProtect, // Read-only protection
	output logic highVectors, // Vector placement
	output logic [31:0] tableBase, // First-level table pointer
	output logic [31:0] domainAccess, // Domain permission fields
	output logic cacheInvalidate, // Whole cache invalidate pulse
	output logic xlatInvalidateAll, // Unlocked entries invalidate pulse
	output logic xlatInvalidateOne, // Single entry invalidate pulse
	output logic [31:0] xlatInvalidateAddr, // Address for single invalidate
	output logic traceIdentifierWritten, // Trace identifier write notify
	output logic [31:0] traceIdentifier // Trace process identifier
);
	import scc_pkg::*;

	logic [31:0] control;
	logic [31:14] tbase;
	logic [8:0] faultStatus;
	logic [31:0] faultAddress;
	logic [6:0] contextId;
	logic wrOk;
	logic rdOk;
	logic sel0;
	logic [31:0] next_readData;

	// Honoured only when privileged; op2 and field qualify some registers
	assign wrOk = xfer.valid && xfer.privileged && xfer.write;
	assign rdOk = xfer.valid && xfer.privileged && !xfer.write;
	assign sel0 = (xfer.op2 == OP2_ZERO);

	// Unprivileged transfer traps
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			undefTrap <= 1'b0;
		end else begin
			undefTrap <= xfer.valid && !xfer.privileged;
		end
	end

	// Control register; bits 4-6 and reserved bits never stored
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			control <= CTL_RESET;
		end else if (wrOk && xfer.regNum == REG_CONTROL) begin
			control <= xfer.data & CTL_WRITABLE_MASK;
		end
	end

	// Control outputs; translation enable waits for pipeline boundary
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			xlatEnable <= 1'b0;
			alignCheck <= 1'b0;
			cacheEnable <= 1'b0;
			wbufEnable <= 1'b0;
			bigEndian <= 1'b0;
			sysProtect <= 1'b0;
			romProtect <= 1'b0;
			highVectors <= 1'b0;
		end else begin
			// Already-fetched instructions keep the old translation state
			if (fetchBoundary) begin
				xlatEnable <= control[CTL_XLAT];
			end
			alignCheck <= control[CTL_ALIGN];
			// Cache and buffer only meaningful with translation on, software's job
			cacheEnable <= control[CTL_CACHE];
			wbufEnable <= control[CTL_WBUF];
			bigEndian <= control[CTL_BIGEND];
			sysProtect <= control[CTL_SYSPROT];
			romProtect <= control[CTL_ROMPROT];
			highVectors <= control[CTL_HIVEC];
		end
	end

	// Table base and domain registers
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			tbase <= '0;
			domainAccess <= WORD_RESET;
		end else if (wrOk) begin
			if (xfer.regNum == REG_TABLE_BASE) begin
				tbase <= xfer.data[31:TBASE_LSB];
			end
			if (xfer.regNum == REG_DOMAIN) begin
				domainAccess <= xfer.data;
			end
		end
	end

	// Table pointer to translation unit, low bits zero
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			tableBase <= WORD_RESET;
		end else begin
			tableBase <= {tbase, 14'h0000};
		end
	end

	// Fault status: software write wins over a simultaneous fault for restore
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			faultStatus <= '0;
			faultAddress <= WORD_RESET;
		end else begin
			if (wrOk && xfer.regNum == REG_FAULT_STATUS) begin
				faultStatus <= xfer.data[8:0] & FSTAT_MASK;
			end else if (fault.valid && !fault.prefetch) begin
				faultStatus <= {1'b0, fault.domain, fault.status};
			end
			if (wrOk && xfer.regNum == REG_FAULT_ADDRESS) begin
				faultAddress <= xfer.data;
			end else if (fault.valid && !fault.prefetch) begin
				faultAddress <= fault.address;
			end
		end
	end

	// Context identifier, relocation input
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			contextId <= CSID_RESET;
		end else if (wrOk && xfer.regNum == REG_PROCESS_ID && sel0) begin
			contextId <= xfer.data[31:CSID_LSB];
		end
	end

	// Low 32MB relocation; fault address arrives already relocated
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			relocAddr <= WORD_RESET;
		end else if (coreAddr[31:CSID_LSB] == 7'h00) begin
			relocAddr <= {contextId, coreAddr[CSID_LSB-1:0]};
		end else begin
			relocAddr <= coreAddr;
		end
	end

	// Trace identifier and one-cycle notify after the write
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			traceIdentifier <= WORD_RESET;
			traceIdentifierWritten <= 1'b0;
		end else begin
			traceIdentifierWritten <= 1'b0;
			if (wrOk && xfer.regNum == REG_PROCESS_ID && xfer.op2 == OP2_ONE) begin
				traceIdentifier <= xfer.data;
				traceIdentifierWritten <= 1'b1;
			end
		end
	end

	// Cache and translation-buffer operation pulses
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			cacheInvalidate <= 1'b0;
			xlatInvalidateAll <= 1'b0;
			xlatInvalidateOne <= 1'b0;
			xlatInvalidateAddr <= WORD_RESET;
		end else begin
			cacheInvalidate <= wrOk && xfer.regNum == REG_CACHE_OPS && sel0
				&& xfer.secField == SEC_FIELD_SEVEN;
			xlatInvalidateAll <= wrOk && xfer.regNum == REG_XLAT_OPS && sel0
				&& xfer.secField == SEC_FIELD_SEVEN;
			xlatInvalidateOne <= wrOk && xfer.regNum == REG_XLAT_OPS && xfer.op2 == OP2_ONE
				&& xfer.secField == SEC_FIELD_SEVEN;
			if (wrOk && xfer.regNum == REG_XLAT_OPS && xfer.op2 == OP2_ONE) begin
				xlatInvalidateAddr <= xfer.data;
			end
		end
	end

	// Read multiplexer; unpredictable fields returned as zero
	always_comb begin
		next_readData = WORD_RESET;
		case (xfer.regNum)
			REG_IDENT: next_readData = IDENT_VALUE;
			REG_CONTROL: next_readData = control | CTL_ONES;
			REG_TABLE_BASE: next_readData = {tbase, 14'h0000};
			REG_DOMAIN: next_readData = domainAccess;
			REG_FAULT_STATUS: next_readData = {23'h000000, faultStatus};
			REG_FAULT_ADDRESS: next_readData = faultAddress;
			REG_PROCESS_ID: next_readData = sel0 ? {contextId, 25'h0000000} : traceIdentifier;
			default: next_readData = WORD_RESET;
		endcase
	end

	// Registered read answer, one cycle after the request
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			readData <= WORD_RESET;
			readValid <= 1'b0;
		end else begin
			readValid <= rdOk;
			if (rdOk) begin
				readData <= next_readData;
			end
		end
	end

	// Read answers; unpredictable bits come back as zero by choice
	ctl_ones_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		rdOk && xfer.regNum == REG_CONTROL |=> readData[6:4] == 3'h7)
		else $error("control ones bits not read as one");

	ctl_read_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		rdOk && xfer.regNum == REG_CONTROL |=> readData == ($past(control) | CTL_ONES))
		else $error("control read value wrong");

	ctl_reserved_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		rdOk && xfer.regNum == REG_CONTROL |=> readData[12:10] == 3'h0 && readData[31:14] == 18'h00000)
		else $error("control reserved bits not zero");

	ident_read_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		rdOk && xfer.regNum == REG_IDENT |=> readData == IDENT_VALUE)
		else $error("identification value wrong");

	tbase_read_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		rdOk && xfer.regNum == REG_TABLE_BASE |=> readData[13:0] == 14'h0000)
		else $error("table base low bits not zero");

	fs_bit8_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		rdOk && xfer.regNum == REG_FAULT_STATUS |=> readData[8] == 1'b0)
		else $error("fault status bit 8 not zero");

	fs_upper_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		rdOk && xfer.regNum == REG_FAULT_STATUS |=> readData[31:9] == 23'h000000)
		else $error("fault status upper bits not zero");

	read_answer_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		rdOk |=> readValid && !undefTrap)
		else $error("privileged read not answered");

	// Control outputs follow the stored word one cycle later
	ctl_write_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		wrOk && xfer.regNum == REG_CONTROL |=> control == ($past(xfer.data) & CTL_WRITABLE_MASK))
		else $error("control write not stored");

	align_follow_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		$past(rst_b) |-> alignCheck == $past(control[CTL_ALIGN]))
		else $error("alignment enable not following control");

	cache_follow_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		$past(rst_b) |-> cacheEnable == $past(control[CTL_CACHE]) && wbufEnable == $past(control[CTL_WBUF]))
		else $error("cache or buffer enable not following control");

	endian_follow_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		$past(rst_b) |-> bigEndian == $past(control[CTL_BIGEND]))
		else $error("byte order not following control");

	prot_follow_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		$past(rst_b) |-> sysProtect == $past(control[CTL_SYSPROT]) && romProtect == $past(control[CTL_ROMPROT]))
		else $error("protection bits not following control");

	hivec_follow_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		$past(rst_b) |-> highVectors == $past(control[CTL_HIVEC]))
		else $error("vector placement not following control");

	// Translation enable only moves at a pipeline boundary
	xlat_hold_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		$past(rst_b) && !$past(fetchBoundary) |-> $stable(xlatEnable))
		else $error("translation enable moved inside pipeline");

	xlat_apply_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		$past(rst_b) && $past(fetchBoundary) |-> xlatEnable == $past(control[CTL_XLAT]))
		else $error("translation enable not applied at boundary");

	// Domain and context identifier writes
	domain_write_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		wrOk && xfer.regNum == REG_DOMAIN |=> domainAccess == $past(xfer.data))
		else $error("domain write not stored");

	ctx_write_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		wrOk && xfer.regNum == REG_PROCESS_ID && sel0 |=> contextId == $past(xfer.data[31:25]))
		else $error("context identifier write not stored");

	// Fault registers: data faults and software restore only
	prefetch_keep_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		fault.valid && fault.prefetch && !wrOk |=> $stable(faultAddress) && $stable(faultStatus))
		else $error("prefetch fault changed fault registers");

	data_fault_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		fault.valid && !fault.prefetch && !wrOk |=> faultAddress == $past(fault.address))
		else $error("data fault address not captured");

	fs_capture_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		fault.valid && !fault.prefetch && !wrOk |=> faultStatus == {1'b0, $past(fault.domain), $past(fault.status)})
		else $error("fault status not captured");

	fs_write_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		wrOk && xfer.regNum == REG_FAULT_STATUS |=> faultStatus == ($past(xfer.data[8:0]) & FSTAT_MASK))
		else $error("fault status restore failed");

	fa_write_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		wrOk && xfer.regNum == REG_FAULT_ADDRESS |=> faultAddress == $past(xfer.data))
		else $error("fault address restore failed");

	// Trace identifier notify
	trace_pulse_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		traceIdentifierWritten |=> !traceIdentifierWritten)
		else $error("trace notify longer than one cycle");

	trace_write_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		wrOk && xfer.regNum == REG_PROCESS_ID && xfer.op2 == OP2_ONE |=> traceIdentifierWritten && traceIdentifier == $past(xfer.data))
		else $error("trace write not notified");

	// Privilege and relocation
	unpriv_trap_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		xfer.valid && !xfer.privileged |=> undefTrap && !readValid && $stable(control))
		else $error("unprivileged transfer not trapped");

	reloc_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		coreAddr[31:25] == 7'h00 |=> relocAddr[31:25] == $past(contextId))
		else $error("low address not relocated");

	reloc_high_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		coreAddr[31:25] != 7'h00 |=> relocAddr == $past(coreAddr))
		else $error("high address was relocated");

	// Maintenance pulses come only from their own selectors
	cache_inv_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		cacheInvalidate |-> $past(wrOk) && $past(xfer.regNum) == REG_CACHE_OPS)
		else $error("spurious cache invalidate");

	xlat_all_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		xlatInvalidateAll |-> $past(wrOk) && $past(xfer.regNum) == REG_XLAT_OPS && $past(xfer.op2) == OP2_ZERO)
		else $error("spurious buffer invalidate");

	xlat_one_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		wrOk && xfer.regNum == REG_XLAT_OPS && xfer.op2 == OP2_ONE && xfer.secField == SEC_FIELD_SEVEN
		|=> xlatInvalidateOne && xlatInvalidateAddr == $past(xfer.data))
		else $error("single entry invalidate missing");

	// Main scenarios reached
	cover_trace_c: cover property (@(posedge core_clk) traceIdentifierWritten);
	cover_fault_c: cover property (@(posedge core_clk) fault.valid && !fault.prefetch);
	cover_xlat_c: cover property (@(posedge core_clk) $rose(xlatEnable));
	cover_trap_c: cover property (@(posedge core_clk) undefTrap);
endmodule

// *** verification/scc_core_model.sv ***
// Core side: issues coprocessor transfers and data fault reports
module scc_core_model (
	input wire logic core_clk, // Processor clock
	output scc_pkg::scc_xfer_s xfer, // Transfer request
	output scc_pkg::scc_fault_s fault, // Fault report
	output logic [31:0] coreAddr, // Core virtual address
	output logic fetchBoundary // Pipeline drained
);
	timeunit 1ns;
	timeprecision 100ps;
	import scc_pkg::*;
	// Idle state at time zero
	initial begin
		xfer = '0;
		fault = '0;
		coreAddr = 32'h00000000;
		fetchBoundary = 1'b1;
	end
	// One-cycle request, entered just after an edge
	task automatic xfer_op(input logic wr, input logic priv, input logic [3:0] rn, input logic [3:0] sf,
			input logic [2:0] o2, input logic [31:0] d);
		xfer = '{valid: 1'b1, write: wr, privileged: priv, regNum: rn, secField: sf, op2: o2, data: d};
		@(posedge core_clk);
		#1;
		xfer.valid = 1'b0;
		xfer.data = ~d; // Released data must not look like the last word
	endtask
	// One-cycle fault report, already relocated
	task automatic fault_op(input logic pf, input logic [3:0] dom, input logic [3:0] st, input logic [31:0] a);
		fault = '{valid: 1'b1, prefetch: pf, domain: dom, status: st, address: a};
		@(posedge core_clk);
		#1;
		fault.valid = 1'b0;
		fault.address = ~a;
	endtask
endmodule

// *** verification/tb.sv ***
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	import scc_pkg::*;
	logic core_clk, rst_b, readValid, undefTrap, xlatEnable, alignCheck, cacheEnable, wbufEnable, bigEndian;
	logic sysProtect, romProtect, highVectors, cacheInvalidate, xlatInvalidateAll, xlatInvalidateOne;
	logic traceIdentifierWritten, fetchBoundary;
	logic [31:0] coreAddr, readData, relocAddr, tableBase, domainAccess, xlatInvalidateAddr, traceIdentifier;
	logic [31:0] d, a;
	logic [31:0] expQ[$];
	scc_xfer_s xfer;
	scc_fault_s fault;
	int failures = 0, n_tests = 0, nCache = 0, nAll = 0, nOne = 0, nTrace = 0, nTrap = 0;
	scc_core_model i_core (.core_clk(core_clk), .xfer(xfer), .fault(fault), .coreAddr(coreAddr),
		.fetchBoundary(fetchBoundary));
	sys_control_coproc_regs i_dut (.core_clk(core_clk), .rst_b(rst_b), .xfer(xfer), .fault(fault),
		.coreAddr(coreAddr), .fetchBoundary(fetchBoundary), .readData(readData), .readValid(readValid),
		.undefTrap(undefTrap), .relocAddr(relocAddr), .xlatEnable(xlatEnable), .alignCheck(alignCheck),
		.cacheEnable(cacheEnable), .wbufEnable(wbufEnable), .bigEndian(bigEndian), .sysProtect(sysProtect),
		.romProtect(romProtect), .highVectors(highVectors), .tableBase(tableBase), .domainAccess(domainAccess),
		.cacheInvalidate(cacheInvalidate), .xlatInvalidateAll(xlatInvalidateAll),
		.xlatInvalidateOne(xlatInvalidateOne), .xlatInvalidateAddr(xlatInvalidateAddr),
		.traceIdentifierWritten(traceIdentifierWritten), .traceIdentifier(traceIdentifier));
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic print_verdict();
		$display("Comparisons %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic wr(input logic [3:0] rn, input logic [3:0] sf, input logic [2:0] o2, input logic [31:0] dv);
		i_core.xfer_op(1'b1, 1'b1, rn, sf, o2, dv);
	endtask
	// Expected word queued before the read goes out
	task automatic rd(input logic [3:0] rn, input logic [2:0] o2, input logic [31:0] exp);
		expQ.push_back(exp);
		i_core.xfer_op(1'b0, 1'b1, rn, 4'h0, o2, $urandom);
	endtask
	// Oldest expectation meets each read result; a stray result is a mismatch too
	always @(negedge core_clk) begin
		if (readValid === 1'b1) begin
			if (expQ.size() == 0) begin
				check("strayRead", 32'h00000001, 32'h00000000);
			end else begin
				check("readData", readData, expQ.pop_front());
			end
		end
	end
	// Pulse counters, so a pulse of wrong length or a missing pulse shows up
	always @(posedge core_clk) begin
		nCache += (cacheInvalidate === 1'b1);
		nAll += (xlatInvalidateAll === 1'b1);
		nOne += (xlatInvalidateOne === 1'b1);
		nTrace += (traceIdentifierWritten === 1'b1);
		nTrap += (undefTrap === 1'b1);
	end
	// Hang guard
	initial begin
		#2000000;
		check("watchdog", 32'h00000001, 32'h00000000);
		print_verdict();
	end
	initial begin
		rst_b = 1'b0;
		void'($urandom(32'h40fc));
		repeat (20) @(posedge core_clk);
		#1 rst_b = 1'b1;
		rd(REG_CONTROL, OP2_ZERO, CTL_RESET | CTL_ONES);
		wr(REG_IDENT, 4'h0, OP2_ZERO, $urandom);
		rd(REG_IDENT, OP2_ZERO, IDENT_VALUE);
		// Translation held off until the pipeline drains; bit 0 set with random writable bits
		i_core.fetchBoundary = 1'b0;
		d = ($urandom & CTL_WRITABLE_MASK) | 32'h00000001; // Reserved bits zero
		wr(REG_CONTROL, 4'h0, OP2_ZERO, d);
		idle(3);
		check("xlatHeld", xlatEnable, 32'h00000000);
		check("ctlOut", {18'h0, highVectors, 3'h0, romProtect, sysProtect, bigEndian, 3'h0, wbufEnable,
			cacheEnable, alignCheck, 1'b0}, d & 32'hFFFFFFFE);
		i_core.fetchBoundary = 1'b1;
		idle(2);
		check("xlatOn", xlatEnable, 32'h00000001);
		rd(REG_CONTROL, OP2_ZERO, d | CTL_ONES);
		d = $urandom;
		wr(REG_TABLE_BASE, 4'h0, OP2_ZERO, d);
		rd(REG_TABLE_BASE, OP2_ZERO, d & 32'hFFFFC000);
		idle(2);
		check("tableBase", tableBase, d & 32'hFFFFC000);
		d = $urandom;
		wr(REG_DOMAIN, 4'h0, OP2_ZERO, d);
		rd(REG_DOMAIN, OP2_ZERO, d);
		check("domain", domainAccess, d);
		// Unprivileged write and read are trapped and change nothing
		i_core.xfer_op(1'b1, 1'b0, REG_DOMAIN, 4'h0, OP2_ZERO, ~d);
		i_core.xfer_op(1'b0, 1'b0, REG_CONTROL, 4'h0, OP2_ZERO, 32'h00000000);
		idle(2);
		check("traps", nTrap, 32'h00000002);
		rd(REG_DOMAIN, OP2_ZERO, d);
		d = $urandom;
		wr(REG_FAULT_STATUS, 4'h0, OP2_ZERO, d);
		rd(REG_FAULT_STATUS, OP2_ZERO, {24'h0, d[7:0]});
		wr(REG_FAULT_ADDRESS, 4'h0, OP2_ZERO, ~d);
		rd(REG_FAULT_ADDRESS, OP2_ZERO, ~d);
		a = $urandom;
		i_core.fault_op(1'b0, 4'hA, 4'h5, a);
		i_core.fault_op(1'b1, 4'h3, 4'hC, ~a); // Prefetch fault leaves both alone
		rd(REG_FAULT_STATUS, OP2_ZERO, 32'h000000A5);
		rd(REG_FAULT_ADDRESS, OP2_ZERO, a);
		// Each maintenance operation once, plus two with wrong selectors
		d = $urandom;
		wr(REG_CACHE_OPS, SEC_FIELD_SEVEN, OP2_ZERO, 32'h00000000);
		wr(REG_XLAT_OPS, SEC_FIELD_SEVEN, OP2_ZERO, 32'h00000000);
		wr(REG_XLAT_OPS, SEC_FIELD_SEVEN, OP2_ONE, d);
		wr(REG_XLAT_OPS, 4'h3, OP2_ZERO, 32'h00000000);
		wr(REG_CACHE_OPS, SEC_FIELD_SEVEN, OP2_ONE, 32'h00000000);
		idle(3);
		check("cacheInv", nCache, 32'h00000001);
		check("xlatAll", nAll, 32'h00000001);
		check("xlatOne", nOne, 32'h00000001);
		check("xlatAddr", xlatInvalidateAddr, d);
		d = $urandom;
		wr(REG_PROCESS_ID, 4'h0, OP2_ZERO, d);
		rd(REG_PROCESS_ID, OP2_ZERO, {d[31:25], 25'h0});
		a = $urandom & 32'h01FFFFFF;
		i_core.coreAddr = a;
		idle(2);
		check("relocLow", relocAddr, {d[31:25], a[24:0]});
		i_core.coreAddr = a | 32'h80000000;
		idle(2);
		check("relocHigh", relocAddr, a | 32'h80000000);
		d = $urandom;
		wr(REG_PROCESS_ID, 4'h0, OP2_ONE, d);
		check("notify", traceIdentifierWritten, 32'h00000001);
		idle(3);
		check("notifyCount", nTrace, 32'h00000001);
		check("traceId", traceIdentifier, d);
		rd(REG_PROCESS_ID, OP2_ONE, d);
		// Second reset in mid-run
		idle(2);
		rst_b = 1'b0;
		idle(2);
		rst_b = 1'b1;
		rd(REG_CONTROL, OP2_ZERO, CTL_ONES);
		rd(REG_PROCESS_ID, OP2_ZERO, 32'h00000000);
		check("xlatReset", xlatEnable, 32'h00000000);
		for (int k = 0; k < 10 && expQ.size() != 0; k++) begin
			idle(1);
		end
		check("readsLeft", expQ.size(), 32'h00000000);
		print_verdict();
	end
endmodule
